/* avg_pulse_params.svh */
// constants for the current average pulse monitor
`ifndef AVG_PULSE_PARAMS_SVH
`define AVG_PULSE_PARAMS_SVH

// clock and time base
`define CLK_PERIOD_NS 10
`define TICK_MS 100
`define TICK_CYCLES_DEF (`TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define HOURS_UNIT_H 100
`define HOURS_UNIT_TICKS_DEF (`HOURS_UNIT_H * 3600 * 1000 / `TICK_MS)

// cycle segment times in ms, counts in ticks
`define CYCLE_MS 20000
`define CYCLE_TICKS (`CYCLE_MS / `TICK_MS)
`define START_MS 1000
`define START_TICKS (`START_MS / `TICK_MS)
`define INVALID_HIGH_MS 3500
`define INVALID_HIGH_TICKS (`INVALID_HIGH_MS / `TICK_MS)
`define CUR_MIN_MS 500
`define CUR_MIN_TICKS (`CUR_MIN_MS / `TICK_MS)
`define PULSE_MAX_MS 9000
`define PULSE_MAX_TICKS (`PULSE_MAX_MS / `TICK_MS)
`define HRS_MIN_MS 2000
`define HRS_MIN_TICKS (`HRS_MIN_MS / `TICK_MS)
`define SCALE_MS 5000
`define SCALE_TICKS (`SCALE_MS / `TICK_MS)
// hours pulse: count*100h/40000h*5s = count/8 ticks
`define HRS_DIV 8
`define HRS_SAT 14'h270E

// register byte offsets
`define OFS_AVG_TIME 8'h00
`define OFS_MASK_TIME 8'h04
`define OFS_REF_CUR 8'h08
`define OFS_HOURS 8'h0C
`define OFS_SEL_A 8'h10
`define OFS_SEL_B 8'h14
`define OFS_STATUS 8'h18

// reset values and ranges, setting times in 0.1 s, current in 0.1 A
`define AVG_TIME_RST 8'h0A
`define AVG_TIME_MIN 8'h01
`define AVG_TIME_MAX 8'h0A
`define MASK_TIME_RST 8'h00
`define MASK_TIME_MAX 8'hC8
`define REF_CUR_MAX 13'h1388
`define SEL_RST 8'h00
`define SEL_POS 8'h5D
`define SEL_NEG 8'hC1

`endif

/* avg_pulse_pkg.sv */
// types for the current average pulse monitor
package avg_pulse_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_MASK = 3'b001,
        ST_START = 3'b010,
        ST_AVG_LOW = 3'b011,
        ST_HRS_HIGH = 3'b100,
        ST_END_LOW = 3'b101,
        ST_INVALID = 3'b110,
        ST_BLANK = 3'b111
    } mon_state_e;
endpackage : avg_pulse_pkg

/* current_average_pulse_monitor.sv */
// pulse coded current average and hours monitor with wishbone registers
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`include "avg_pulse_params.svh"

// Overview of operation
// - repeat 20 s cycles during constant speed
// - 1 s high start pulse, current averaged
// - averaging window 0.1 to 1.0 s
// - mask 0 to 20 s after reaching constant
// - reference current 0 to 500 A is 100%
// - low pulse = avg/ref times 5 s
// - low pulse clamped 0.5 s to 9 s
// - hours high pulse follows current low pulse
// - hours pulse = count*100/40000h times 5 s
// - hours pulse clamped 2 s to 9 s
// - no mask or sampling while accel/decel
// - speed lost in start: 3.5 s high, 16.5 low
// - after start pulse, finish the cycle
// - zero current at end: wait next constant
// - 20 s low without data in three cases
// - only open collector outputs, 93/193 polarity
// - hours counter in 100 h, saturates 9998
module current_average_pulse_monitor
    import avg_pulse_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES_DEF,
    parameter int HOURS_UNIT_TICKS = `HOURS_UNIT_TICKS_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic const_speed_i,
    input wire logic accel_decel_i,
    input wire logic restart_active_i,
    input wire logic [15:0] out_current_i,
    output logic oc_term_a_o,
    output logic oc_term_b_o
);

    localparam logic [12:0] RATED_CUR = 13'h0064; // rated current, 0.1 A

    // polarity selection decode used for both terminals
    function automatic logic term_level(input logic [7:0] sel,
                                        input logic mon);
        if (sel == `SEL_POS) begin
            term_level = mon;
        end else if (sel == `SEL_NEG) begin
            term_level = ~mon;
        end else begin
            term_level = 1'b0; // not assigned: terminal idle
        end
    endfunction : term_level

    // state of the time bases
    logic [23:0] tick_cnt_ff, nxt_tick_cnt;
    logic [21:0] hour_cnt_ff, nxt_hour_cnt;
    logic [13:0] hours_ff, nxt_hours;
    logic tick;

    // register file state
    logic [7:0] avg_time_ff, nxt_avg_time;
    logic [7:0] mask_time_ff, nxt_mask_time;
    logic [12:0] ref_cur_ff, nxt_ref_cur;
    logic [7:0] sel_a_ff, nxt_sel_a;
    logic [7:0] sel_b_ff, nxt_sel_b;
    logic [31:0] rd_data_ff, nxt_rd_data;
    logic ack_ff, nxt_ack;

    // monitor sequence state
    mon_state_e state_ff, nxt_state;
    logic [7:0] cyc_cnt_ff, nxt_cyc_cnt;
    logic [7:0] seg_cnt_ff, nxt_seg_cnt;
    logic [19:0] sum_ff, nxt_sum;
    logic [3:0] nsamp_ff, nxt_nsamp;
    logic [27:0] acc_ff, nxt_acc;
    logic suppress_ff, nxt_suppress;
    logic mon_ff, nxt_mon;
    logic term_a_ff, nxt_term_a;
    logic term_b_ff, nxt_term_b;

    logic bus_req;
    logic [7:0] seg_inc;
    logic [27:0] acc_step;
    logic [27:0] target;
    logic cycle_end;
    mon_state_e end_choice;

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign tick = (tick_cnt_ff == 24'(TICK_CYCLES - 1));

    // 0.1 s tick and energization hours counter
    always_comb begin
        nxt_tick_cnt = tick ? 24'h000000 : tick_cnt_ff + 24'h000001;
        nxt_hour_cnt = hour_cnt_ff;
        nxt_hours = hours_ff;
        if (tick) begin
            if (hour_cnt_ff == 22'(HOURS_UNIT_TICKS - 1)) begin
                nxt_hour_cnt = 22'h000000;
                if (hours_ff != `HRS_SAT) begin
                    nxt_hours = hours_ff + 14'h0001;
                end
            end else begin
                nxt_hour_cnt = hour_cnt_ff + 22'h000001;
            end
        end
        // writing zero clears a nonzero count
        if (bus_req && wb_we_i && wb_adr_i == `OFS_HOURS && wb_sel_i[0]
            && wb_dat_i[13:0] == 14'h0000 && hours_ff != 14'h0000) begin
            nxt_hours = 14'h0000;
            nxt_hour_cnt = 22'h000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_ff <= 24'h000000;
            hour_cnt_ff <= 22'h000000;
            hours_ff <= 14'h0000;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            hour_cnt_ff <= nxt_hour_cnt;
            hours_ff <= nxt_hours;
        end
    end

    // wishbone slave: one wait state, unmapped reads zero
    always_comb begin
        nxt_ack = bus_req;
        nxt_rd_data = 32'h00000000;
        nxt_avg_time = avg_time_ff;
        nxt_mask_time = mask_time_ff;
        nxt_ref_cur = ref_cur_ff;
        nxt_sel_a = sel_a_ff;
        nxt_sel_b = sel_b_ff;
        if (bus_req && wb_we_i) begin
            unique case (wb_adr_i)
                `OFS_AVG_TIME: if (wb_sel_i[0]) begin
                    if (wb_dat_i[7:0] < `AVG_TIME_MIN) begin
                        nxt_avg_time = `AVG_TIME_MIN;
                    end else if (wb_dat_i[7:0] > `AVG_TIME_MAX) begin
                        nxt_avg_time = `AVG_TIME_MAX;
                    end else begin
                        nxt_avg_time = wb_dat_i[7:0];
                    end
                end
                `OFS_MASK_TIME: if (wb_sel_i[0]) begin
                    nxt_mask_time = (wb_dat_i[7:0] > `MASK_TIME_MAX) ?
                        `MASK_TIME_MAX : wb_dat_i[7:0];
                end
                `OFS_REF_CUR: if (wb_sel_i[1:0] == 2'b11) begin
                    nxt_ref_cur = (wb_dat_i[15:0] > 16'(`REF_CUR_MAX)) ?
                        `REF_CUR_MAX : wb_dat_i[12:0];
                end
                `OFS_SEL_A: if (wb_sel_i[0]) nxt_sel_a = wb_dat_i[7:0];
                `OFS_SEL_B: if (wb_sel_i[0]) nxt_sel_b = wb_dat_i[7:0];
                default: ;
            endcase
        end else if (bus_req) begin
            unique case (wb_adr_i)
                `OFS_AVG_TIME: nxt_rd_data = {24'h000000, avg_time_ff};
                `OFS_MASK_TIME: nxt_rd_data = {24'h000000, mask_time_ff};
                `OFS_REF_CUR: nxt_rd_data = {19'h00000, ref_cur_ff};
                `OFS_HOURS: nxt_rd_data = {18'h00000, hours_ff};
                `OFS_SEL_A: nxt_rd_data = {24'h000000, sel_a_ff};
                `OFS_SEL_B: nxt_rd_data = {24'h000000, sel_b_ff};
                `OFS_STATUS: nxt_rd_data = {8'h00, cyc_cnt_ff, 3'h0,
                    suppress_ff, mon_ff, state_ff, 8'h00};
                default: nxt_rd_data = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rd_data_ff <= 32'h00000000;
            avg_time_ff <= `AVG_TIME_RST;
            mask_time_ff <= `MASK_TIME_RST;
            ref_cur_ff <= RATED_CUR;
            sel_a_ff <= `SEL_RST;
            sel_b_ff <= `SEL_RST;
        end else begin
            ack_ff <= nxt_ack;
            rd_data_ff <= nxt_rd_data;
            avg_time_ff <= nxt_avg_time;
            mask_time_ff <= nxt_mask_time;
            ref_cur_ff <= nxt_ref_cur;
            sel_a_ff <= nxt_sel_a;
            sel_b_ff <= nxt_sel_b;
        end
    end

    assign seg_inc = seg_cnt_ff + 8'h01;
    assign acc_step = 28'(ref_cur_ff) * 28'(nsamp_ff);
    assign target = 28'(sum_ff * `SCALE_TICKS);
    assign cycle_end = tick && cyc_cnt_ff == 8'(`CYCLE_TICKS - 1);

    // what follows a finished cycle
    always_comb begin
        if (out_current_i == 16'h0000) begin
            end_choice = ST_IDLE;
        end else if (accel_decel_i || restart_active_i) begin
            end_choice = ST_BLANK;
        end else if (!const_speed_i) begin
            end_choice = ST_IDLE;
        end else begin
            end_choice = ST_START;
        end
    end

    // monitor sequence
    always_comb begin
        nxt_state = state_ff;
        nxt_cyc_cnt = tick ? cyc_cnt_ff + 8'h01 : cyc_cnt_ff;
        nxt_seg_cnt = tick ? seg_inc : seg_cnt_ff;
        nxt_sum = sum_ff;
        nxt_nsamp = nsamp_ff;
        nxt_acc = acc_ff;
        nxt_suppress = suppress_ff & const_speed_i;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_seg_cnt = 8'h00;
                if (const_speed_i && !accel_decel_i && !suppress_ff) begin
                    nxt_state = ST_MASK;
                end
            end
            ST_MASK: begin
                nxt_cyc_cnt = 8'h00;
                nxt_sum = 20'h00000;
                nxt_nsamp = 4'h0;
                if (accel_decel_i || !const_speed_i) begin
                    nxt_state = ST_IDLE;
                end else if (seg_cnt_ff >= mask_time_ff) begin
                    nxt_seg_cnt = 8'h00;
                    nxt_state = restart_active_i ? ST_BLANK : ST_START;
                end
            end
            ST_START: begin
                if (accel_decel_i) begin
                    nxt_state = ST_INVALID;
                end else if (tick) begin
                    if (seg_cnt_ff < avg_time_ff) begin
                        nxt_sum = sum_ff + 20'(out_current_i);
                        nxt_nsamp = nsamp_ff + 4'h1;
                    end
                    if (seg_inc == 8'(`START_TICKS)) begin
                        nxt_seg_cnt = 8'h00;
                        nxt_acc = 28'h0000000;
                        nxt_state = ST_AVG_LOW;
                    end
                end
            end
            ST_AVG_LOW: if (tick) begin
                nxt_acc = acc_ff + acc_step;
                // width = sum*5s / (ref*n), kept in 0.5..9 s
                if ((seg_inc >= 8'(`CUR_MIN_TICKS) && nxt_acc >= target)
                    || seg_inc == 8'(`PULSE_MAX_TICKS)) begin
                    nxt_seg_cnt = 8'h00;
                    nxt_state = ST_HRS_HIGH;
                end
            end
            ST_HRS_HIGH: if (tick) begin
                if ((seg_inc >= 8'(`HRS_MIN_TICKS) &&
                     17'(seg_inc) * 17'(`HRS_DIV) >= 17'(hours_ff))
                    || seg_inc == 8'(`PULSE_MAX_TICKS)) begin
                    nxt_state = ST_END_LOW;
                end
            end
            ST_END_LOW, ST_INVALID, ST_BLANK: if (cycle_end) begin
                nxt_cyc_cnt = 8'h00;
                nxt_seg_cnt = 8'h00;
                nxt_sum = 20'h00000;
                nxt_nsamp = 4'h0;
                nxt_state = (state_ff == ST_BLANK && end_choice == ST_BLANK)
                    ? ST_IDLE : end_choice;
                if (out_current_i == 16'h0000) begin
                    nxt_suppress = const_speed_i;
                end
            end
        endcase
        // output level for the next cycle
        unique case (nxt_state)
            ST_START, ST_HRS_HIGH: nxt_mon = 1'b1;
            ST_INVALID: nxt_mon = (nxt_cyc_cnt <
                8'(`INVALID_HIGH_TICKS));
            default: nxt_mon = 1'b0;
        endcase
        nxt_term_a = term_level(sel_a_ff, nxt_mon);
        nxt_term_b = term_level(sel_b_ff, nxt_mon);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cyc_cnt_ff <= 8'h00;
            seg_cnt_ff <= 8'h00;
            sum_ff <= 20'h00000;
            nsamp_ff <= 4'h0;
            acc_ff <= 28'h0000000;
            suppress_ff <= 1'b0;
            mon_ff <= 1'b0;
            term_a_ff <= 1'b0;
            term_b_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cyc_cnt_ff <= nxt_cyc_cnt;
            seg_cnt_ff <= nxt_seg_cnt;
            sum_ff <= nxt_sum;
            nsamp_ff <= nxt_nsamp;
            acc_ff <= nxt_acc;
            suppress_ff <= nxt_suppress;
            mon_ff <= nxt_mon;
            term_a_ff <= nxt_term_a;
            term_b_ff <= nxt_term_b;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rd_data_ff;
    assign oc_term_a_o = term_a_ff;
    assign oc_term_b_o = term_b_ff;

endmodule : current_average_pulse_monitor

/* avg_pulse_monitor_checker.sv */
// port checker for the current average pulse monitor
`timescale 1ns/1ns
`include "avg_pulse_params.svh"
module avg_pulse_monitor_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic oc_term_a_o,
    input wire logic oc_term_b_o
);
    logic [7:0] sel_a_ff, sel_b_ff, nxt_sel_a, nxt_sel_b;
    logic [31:0] hi_ff, lo_ff, per_ff, nxt_hi, nxt_lo, nxt_per;
    logic wr_done, pos_mon, pol_ok, no_sel;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // track terminal selects and run lengths of the monitor level
    always_comb begin
        wr_done = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
        nxt_sel_a = sel_a_ff;
        nxt_sel_b = sel_b_ff;
        if (wr_done && wb_adr_i == `OFS_SEL_A)
            nxt_sel_a = wb_dat_i[7:0];
        if (wr_done && wb_adr_i == `OFS_SEL_B)
            nxt_sel_b = wb_dat_i[7:0];
        pos_mon = sel_a_ff == `SEL_POS;
        pol_ok = pos_mon && sel_b_ff == `SEL_NEG;
        no_sel = sel_a_ff != `SEL_POS && sel_a_ff != `SEL_NEG;
        nxt_hi = oc_term_a_o ? hi_ff + 32'h1 : 32'h0;
        nxt_lo = oc_term_a_o ? 32'h0 : lo_ff + 32'h1;
        // restart the period count at the end of each start pulse
        nxt_per = (!oc_term_a_o && hi_ff != 0 && hi_ff <= 10 * TICK_CYCLES)
            ? 32'h1 : per_ff + 32'h1;
    end
    // helper registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_a_ff <= 8'h00;
            sel_b_ff <= 8'h00;
            hi_ff <= 32'h0;
            lo_ff <= 32'h0;
            per_ff <= 32'h0000FFFF;
        end else begin
            sel_a_ff <= nxt_sel_a;
            sel_b_ff <= nxt_sel_b;
            hi_ff <= nxt_hi;
            lo_ff <= nxt_lo;
            per_ff <= nxt_per;
        end
    end
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data idle");
    property p_rst_quiet;
        disable iff (1'b0) rst_i |=> !oc_term_a_o && !oc_term_b_o && !wb_ack_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset outputs");
    property p_polarity;
        pol_ok ##1 pol_ok |-> oc_term_b_o != oc_term_a_o;
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity");
    property p_unassigned;
        no_sel ##1 no_sel |-> !oc_term_a_o;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unused");
    property p_high_run;
        $fell(oc_term_a_o) && pos_mon |->
            hi_ff > 9 * TICK_CYCLES && hi_ff <= 90 * TICK_CYCLES;
    endproperty
    a_high_run: assert property (p_high_run) else $error("high");
    property p_low_run;
        $rose(oc_term_a_o) && pos_mon |-> lo_ff >= 5 * TICK_CYCLES;
    endproperty
    a_low_run: assert property (p_low_run) else $error("low run");
    property p_period;
        $fell(oc_term_a_o) && pos_mon && hi_ff <= 10 * TICK_CYCLES |->
            per_ff >= 199 * TICK_CYCLES;
    endproperty
    a_period: assert property (p_period) else $error("period");
    c_start: cover property ($rose(oc_term_a_o) && pos_mon);
    c_write: cover property (wr_done);
    c_long: cover property ($fell(oc_term_a_o) && hi_ff >= 30 * TICK_CYCLES);
endmodule : avg_pulse_monitor_checker

bind current_average_pulse_monitor avg_pulse_monitor_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .oc_term_a_o(oc_term_a_o), .oc_term_b_o(oc_term_b_o)
);

/* plc_pulse_meter.sv */
// pulse width meter standing in for the controller input module
`timescale 1ns/1ns
module plc_pulse_meter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic level_i,
    output logic [31:0] hi_w_o,
    output logic [31:0] lo_w_o
);
    logic prev_ff;
    logic [31:0] cnt_ff, nxt_cnt, nxt_hi, nxt_lo;
    // at each level change keep the length of the finished run
    always_comb begin
        nxt_cnt = cnt_ff + 32'h1;
        nxt_hi = hi_w_o;
        nxt_lo = lo_w_o;
        if (level_i != prev_ff) begin
            nxt_cnt = 32'h1;
            if (prev_ff)
                nxt_hi = cnt_ff;
            else
                nxt_lo = cnt_ff;
        end
    end
    // sample the terminal once a clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= 1'b0;
            cnt_ff <= 32'h0;
            hi_w_o <= 32'h0;
            lo_w_o <= 32'h0;
        end else begin
            prev_ff <= level_i;
            cnt_ff <= nxt_cnt;
            hi_w_o <= nxt_hi;
            lo_w_o <= nxt_lo;
        end
    end
endmodule : plc_pulse_meter

/* tb_top.sv */
// testbench: register access and pulse timing of the monitor
`timescale 1ns/1ns
`include "avg_pulse_params.svh"
module tb_top;
    localparam int T = 4;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, hi_w, lo_w;
    logic wb_ack_o, oc_term_a_o, oc_term_b_o, hit;
    logic const_speed_i = 1'b0, accel_decel_i = 1'b0, restart_active_i = 1'b0;
    logic [15:0] out_current_i = 16'h0000;
    logic [15:0] cur_tab [4] = '{16'h0096, 16'h0005, 16'h00C8, 16'h0032};
    int w_tab [4] = '{75, 5, 90, 25};
    int n_errors = 0, compares = 0, nw;
    always #5 clk_i = ~clk_i;
    current_average_pulse_monitor #(.TICK_CYCLES(T), .HOURS_UNIT_TICKS(1000000))
    dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .const_speed_i(const_speed_i), .accel_decel_i(accel_decel_i),
        .restart_active_i(restart_active_i), .out_current_i(out_current_i),
        .oc_term_a_o(oc_term_a_o), .oc_term_b_o(oc_term_b_o));
    plc_pulse_meter plc (.clk_i(clk_i), .rst_i(rst_i), .level_i(oc_term_a_o),
        .hi_w_o(hi_w), .lo_w_o(lo_w));
    task complete_run;
        if (n_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task wb_io(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            chk("ack", wb_ack_o, 1'b1);
            complete_run();
        end
    endtask : wb_io
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_io(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_io(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), q, exp);
    endtask : rd
    // wait for a terminal level; the meter has the run one clock later
    task wait_term(input logic v, input int lim, input bit must);
        nw = 0;
        hit = 1'b0;
        while (!hit && nw < lim) begin
            @(posedge clk_i);
            nw++;
            hit = (oc_term_a_o === v);
        end
        @(posedge clk_i);
        if (must && !hit) begin
            chk("term level", hit, 1'b1);
            complete_run();
        end
    endtask : wait_term
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`OFS_AVG_TIME, 32'h0000000A);
        rd(`OFS_MASK_TIME, 32'h00000000);
        rd(`OFS_REF_CUR, 32'h00000064);
        rd(`OFS_HOURS, 32'h00000000);
        wr(8'h1C, 32'h000000FF);
        rd(8'h1C, 32'h00000000);
        wr(`OFS_AVG_TIME, 32'h00000000);
        rd(`OFS_AVG_TIME, 32'h00000001);
        wr(`OFS_AVG_TIME, 32'h000000FF);
        rd(`OFS_AVG_TIME, 32'h0000000A);
        wr(`OFS_MASK_TIME, 32'h000000FF);
        rd(`OFS_MASK_TIME, 32'h000000C8);
        wr(`OFS_MASK_TIME, 32'h00000000);
        wr(`OFS_SEL_A, {24'h0, `SEL_POS});
        wr(`OFS_SEL_B, {24'h0, `SEL_NEG});
        rd(`OFS_SEL_B, {24'h0, `SEL_NEG});
        const_speed_i <= 1'b1;
        // back to back cycles over a table of currents
        for (int i = 0; i < 4; i++) begin
            out_current_i <= cur_tab[i];
            wait_term(1'b1, 300 * T, 1'b1);
            if (i > 0)
                chk("end low", lo_w, (170 - w_tab[i - 1]) * T);
            wait_term(1'b0, 20 * T, 1'b1);
            chk("start", (hi_w + T - 1) / T, 10);
            wait_term(1'b1, 100 * T, 1'b1);
            chk("avg low", lo_w, w_tab[i] * T);
            wait_term(1'b0, 100 * T, 1'b1);
            chk("hours high", hi_w, 20 * T);
        end
        out_current_i <= 16'h0000;
        wait_term(1'b1, 300 * T, 1'b0);
        chk("zero current", hit, 1'b0);
        const_speed_i <= 1'b0;
        out_current_i <= 16'h0096;
        @(posedge clk_i);
        const_speed_i <= 1'b1;
        wait_term(1'b1, 20 * T, 1'b1);
        repeat (5 * T) @(posedge clk_i);
        accel_decel_i <= 1'b1;
        const_speed_i <= 1'b0;
        wait_term(1'b0, 40 * T, 1'b1);
        chk("invalid high", (hi_w + T - 1) / T, 35);
        wait_term(1'b1, 400 * T, 1'b0);
        chk("held low", hit, 1'b0);
        wr(`OFS_MASK_TIME, 32'h00000014);
        accel_decel_i <= 1'b0;
        restart_active_i <= 1'b1;
        const_speed_i <= 1'b1;
        wait_term(1'b1, 150 * T, 1'b0);
        chk("restart blank", hit, 1'b0);
        restart_active_i <= 1'b0;
        const_speed_i <= 1'b0;
        wait_term(1'b1, 200 * T, 1'b0);
        chk("blank end", hit, 1'b0);
        const_speed_i <= 1'b1;
        wait_term(1'b1, 40 * T, 1'b1);
        chk("mask", nw >= 19 * T && nw <= 22 * T, 1'b1);
        wait_term(1'b0, 20 * T, 1'b1);
        accel_decel_i <= 1'b1;
        const_speed_i <= 1'b0;
        wait_term(1'b1, 100 * T, 1'b1);
        chk("finish cycle", lo_w, 75 * T);
        complete_run();
    end
endmodule : tb_top
